// ### rtl/drdy_gate_pkg.sv
// Purpose: Shared constants and carriers for driver-ready start gating
// Assumes: 100 MHz system clock
// Notes:   Setting storage is modelled as a saved bit plus a valid flag
package drdy_gate_pkg;

    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned WAIT_TIME_MS    = 3000;
    localparam int unsigned WAIT_CYCLES     = (CLK_HZ / 1000) * WAIT_TIME_MS;
    localparam int unsigned WAIT_CNT_W      = 29;
    localparam logic [7:0]  ALARM_CODE_CONN = 8'h6F;
    localparam logic        CHECK_FACTORY   = 1'b0;

    // Setting access from the command interpreter
    typedef struct packed {
        logic wr;          // Write strobe for the pending value
        logic from_seq;    // Access comes from a running sequence program
        logic wdata;       // Value to write
        logic save;        // save_parameters_command pulse
    } setting_req_type;

    // Motion context from the rest of the controller
    typedef struct packed {
        logic start;       // One-cycle motion start request
        logic moving;
        logic running;
        logic alarm_clr;   // Clears the latched connection alarm
    } motion_ctx_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_GO
    } gate_state_type;

endpackage : drdy_gate_pkg

// ### rtl/drdy_setting_store.sv
// Purpose: One-bit driver-ready check setting with pending, saved and live copies
// Assumes: Saved copy stands in for nonvolatile storage across warm resets
// Notes:   Live value changes only at reset release
`timescale 1ns/100ps
module drdy_setting_store
(
    // Clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_n_i,
    // Storage image presented at power up
    input  wire logic                            nv_valid_i,
    input  wire logic                            nv_value_i,
    // Access
    input  wire drdy_gate_pkg::setting_req_type  req_i,
    output logic                                 pending_o,
    output logic                                 saved_o,
    output logic                                 save_done_o,
    output logic                                 wr_refused_o,
    output logic                                 live_o
);

    typedef struct packed {
        logic loaded;
        logic live;
        logic pending;
        logic saved;
        logic save_done;
        logic refused;
    } store_state_type;

    store_state_type st_r;
    store_state_type st_nxt;

    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.save_done = 1'b0;
        st_nxt.refused   = 1'b0;
        if (!st_r.loaded)
        begin
            // First cycle after release: last saved value or factory default
            st_nxt.loaded  = 1'b1;
            st_nxt.live    = nv_valid_i ? nv_value_i : drdy_gate_pkg::CHECK_FACTORY;
            st_nxt.pending = st_nxt.live;
            st_nxt.saved   = st_nxt.live;
        end
        else
        begin
            if (req_i.wr && req_i.from_seq)
                st_nxt.refused = 1'b1;
            else if (req_i.wr)
                st_nxt.pending = req_i.wdata;
            if (req_i.save)
            begin
                st_nxt.saved     = st_r.pending;
                st_nxt.save_done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign pending_o    = st_r.pending;
    assign saved_o      = st_r.saved;
    assign save_done_o  = st_r.save_done;
    assign wr_refused_o = st_r.refused;
    assign live_o       = st_r.live;

    a_live_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.loaded && $past(st_r.loaded) |-> st_r.live == $past(st_r.live))
        else $error("live setting changed without reset");

    a_seq_refused: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st_r.loaded && req_i.wr && req_i.from_seq |=> st_r.pending == $past(st_r.pending)
            && st_r.refused)
        else $error("sequence write not refused");

endmodule : drdy_setting_store

// ### rtl/drdy_start_gate.sv
// Purpose: Gate motion start on driver ready, time out, drive ready output
// Assumes: All inputs synchronous to sys_clk_i
// Notes:   Setting takes effect only after a reset following a save
`timescale 1ns/100ps

// Functional notes
// - One-bit check setting, 0 disables and 1 enables driver-ready checking.
// - Setting defaults to 0 when nothing was ever saved.
// - New setting applies only after save and reset; power up loads saved value.
// - Immediate commands read and write setting; sequence writes are refused.
// - Enabled and driver ready at start: pulses begin at once.
// - Enabled and driver not ready: hold start until driver ready asserts.
// - No driver ready three seconds after start: abandon, raise alarm 6Fh.
// - Enabled: ready output when idle, no program, no alarm and driver ready.
// - Disabled: ready output when idle, no program, no alarm.
module drdy_start_gate
#(
    parameter int unsigned WAIT_CYCLES = drdy_gate_pkg::WAIT_CYCLES
)
(
    // Clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_n_i,
    // Saved setting image at power up
    input  wire logic                            nv_valid_i,
    input  wire logic                            nv_value_i,
    // Setting access
    input  wire drdy_gate_pkg::setting_req_type  setting_req_i,
    output logic                                 driver_ready_check_enable_o,
    output logic                                 check_pending_o,
    output logic                                 check_saved_o,
    output logic                                 save_done_o,
    output logic                                 write_refused_o,
    // Motion context
    input  wire drdy_gate_pkg::motion_ctx_type   motion_i,
    input  wire logic                            driver_ready_i,
    // Results
    output logic                                 pulse_start_o,
    output logic                                 start_waiting_o,
    output logic                                 conn_alarm_o,
    output logic [7:0]                           alarm_code_o,
    output logic                                 driver_ready_input_status_o,
    output logic                                 ready_local_o,
    output logic                                 ready_remote_o
);

    localparam int unsigned CNT_W = drdy_gate_pkg::WAIT_CNT_W;
    // Counter stops one short: the alarm edge itself is the last waiting cycle
    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_CYCLES - 1);

    typedef struct packed {
        drdy_gate_pkg::gate_state_type    state;
        logic [drdy_gate_pkg::WAIT_CNT_W-1:0] cnt;
        logic                             pulse;
        logic                             alarm;
        logic [7:0]                       code;
        logic                             drv_seen;
        logic                             ready;
        logic                             loaded;
    } gate_reg_type;

    gate_reg_type r_r;
    gate_reg_type r_nxt;
    logic         check_en;
    logic         idle_ok;

    drdy_setting_store u_store
    (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .nv_valid_i   (nv_valid_i),
        .nv_value_i   (nv_value_i),
        .req_i        (setting_req_i),
        .pending_o    (check_pending_o),
        .saved_o      (check_saved_o),
        .save_done_o  (save_done_o),
        .wr_refused_o (write_refused_o),
        .live_o       (check_en)
    );

    // Idle means no motion, no program, no alarm and no start in progress.
    // Live setting is not valid in the load cycle after reset, so ready
    // and starts wait one cycle rather than act on a stale disabled check.
    assign idle_ok = !motion_i.moving && !motion_i.running && !r_r.alarm
                     && (r_r.state == drdy_gate_pkg::ST_IDLE) && r_r.loaded;

    always_comb
    begin
        r_nxt          = r_r;
        r_nxt.pulse    = 1'b0;
        r_nxt.drv_seen = driver_ready_i;
        r_nxt.loaded   = 1'b1;
        r_nxt.ready    = idle_ok && (!check_en || driver_ready_i);
        if (motion_i.alarm_clr)
        begin
            r_nxt.alarm = 1'b0;
            r_nxt.code  = 8'h00;
        end
        case (r_r.state)
            drdy_gate_pkg::ST_IDLE:
            begin
                if (motion_i.start && !r_r.alarm && r_r.loaded)
                begin
                    r_nxt.cnt = '0;
                    if (!check_en || driver_ready_i)
                    begin
                        r_nxt.pulse = 1'b1;
                        r_nxt.state = drdy_gate_pkg::ST_GO;
                    end
                    else
                        r_nxt.state = drdy_gate_pkg::ST_WAIT;
                end
            end
            drdy_gate_pkg::ST_WAIT:
            begin
                if (driver_ready_i)
                begin
                    r_nxt.cnt   = '0;
                    r_nxt.pulse = 1'b1;
                    r_nxt.state = drdy_gate_pkg::ST_GO;
                end
                else if (motion_i.start)
                    r_nxt.cnt = '0;
                else if (r_r.cnt == WAIT_LAST)
                begin
                    // Timeout wins over a late clear in the same cycle
                    r_nxt.alarm = 1'b1;
                    r_nxt.code  = drdy_gate_pkg::ALARM_CODE_CONN;
                    r_nxt.state = drdy_gate_pkg::ST_IDLE;
                    r_nxt.cnt   = '0;
                end
                else
                    r_nxt.cnt = r_r.cnt + 1'b1;
            end
            drdy_gate_pkg::ST_GO:
                r_nxt.state = drdy_gate_pkg::ST_IDLE;
            default:
                r_nxt.state = drdy_gate_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r_r <= '{state: drdy_gate_pkg::ST_IDLE, default: '0};
        else
            r_r <= r_nxt;
    end

    assign driver_ready_check_enable_o = check_en;
    assign pulse_start_o               = r_r.pulse;
    assign start_waiting_o             = (r_r.state == drdy_gate_pkg::ST_WAIT);
    assign conn_alarm_o                = r_r.alarm;
    assign alarm_code_o                = r_r.code;
    assign driver_ready_input_status_o = r_r.drv_seen;
    assign ready_local_o               = r_r.ready;
    assign ready_remote_o              = r_r.ready;

    a_start_now: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.state == drdy_gate_pkg::ST_IDLE && motion_i.start && !r_r.alarm
        && r_r.loaded && (!check_en || driver_ready_i) |=> pulse_start_o)
        else $error("start with driver ready not immediate");

    a_start_held: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.state == drdy_gate_pkg::ST_WAIT && !driver_ready_i |=> !pulse_start_o)
        else $error("pulses began while driver not ready");

    a_wait_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.state == drdy_gate_pkg::ST_WAIT && driver_ready_i
        |=> pulse_start_o && r_r.cnt == '0)
        else $error("start not released on driver ready");

    a_timeout_alarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.state == drdy_gate_pkg::ST_WAIT && !driver_ready_i && !motion_i.start
        && r_r.cnt == WAIT_LAST
        |=> conn_alarm_o && alarm_code_o == 8'h6F && !start_waiting_o)
        else $error("timeout did not raise alarm 6Fh");

    a_alarm_latched: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        conn_alarm_o && !motion_i.alarm_clr |=> conn_alarm_o)
        else $error("alarm dropped without clear");

    a_ready_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ready_local_o |-> !$past(motion_i.moving) && !$past(motion_i.running)
        && !$past(conn_alarm_o) && (!check_en || $past(driver_ready_i)))
        else $error("ready output while busy or driver not ready");

    a_ready_nocheck: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !check_en && idle_ok |=> ready_local_o && ready_remote_o)
        else $error("ready missing with check disabled");

    a_no_early_alarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(conn_alarm_o) |-> $past(r_r.cnt) == WAIT_LAST)
        else $error("alarm before full wait");

    a_pulse_single: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        pulse_start_o |=> !pulse_start_o)
        else $error("start pulse longer than one cycle");

    a_alarm_blocks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        conn_alarm_o |=> !pulse_start_o)
        else $error("start accepted while alarm latched");

    a_code_tracks: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        alarm_code_o == (conn_alarm_o ? 8'h6F : 8'h00))
        else $error("alarm code does not match alarm state");

    a_cnt_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.state == drdy_gate_pkg::ST_WAIT |-> r_r.cnt <= WAIT_LAST)
        else $error("wait counter beyond its last value");

    a_ready_pair: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ready_local_o == ready_remote_o)
        else $error("local and remote ready differ");

    a_status_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        r_r.loaded |-> driver_ready_input_status_o == $past(driver_ready_i))
        else $error("driver ready status not one cycle behind input");

    a_wait_blocks_ready: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        start_waiting_o |=> !ready_local_o)
        else $error("ready output while a start is waiting");

    a_load_guard: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !r_r.loaded |=> !pulse_start_o && !ready_local_o)
        else $error("start or ready acted on before the setting loaded");

endmodule : drdy_start_gate

// ### tb/drv_model.sv
// Purpose: Motor driver model, operation-ready output only
// Assumes: Bench powers the driver; ready follows after a settling delay
// Notes:   No pull on the ready line, so unpowered it reads low
`timescale 1ns/100ps
module drv_model
#(
    parameter int unsigned SETTLE = 10
)
(
    // Clock
    input  wire logic sys_clk_i,
    // Bench control
    input  wire logic power_i,
    // Driver output
    output logic      ready_o
);
    int unsigned cnt = 0;

    always @(posedge sys_clk_i)
    begin
        if (!power_i)
        begin
            cnt = 0;
        end
        else if (cnt < SETTLE)
        begin
            cnt = cnt + 1;
        end
        ready_o <= power_i && (cnt >= SETTLE);
    end
endmodule : drv_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for driver-ready start gating
// Assumes: Wait count shortened to 50 cycles
// Notes:   Inputs change on the falling edge only
`timescale 1ns/100ps
module testbench;
    logic sys_clk_i, rst_n_i, nv_valid_i, nv_value_i, power;
    drdy_gate_pkg::setting_req_type req;
    drdy_gate_pkg::motion_ctx_type  mot;
    logic live, pend, saved, sdone, refused, drdy, pulse, waiting, alarm, stat, rdy_l, rdy_r;
    logic [7:0] code;
    int n_errors, n_compared, cycles;

    drv_model #(.SETTLE(10)) drv (.sys_clk_i(sys_clk_i), .power_i(power), .ready_o(drdy));

    drdy_start_gate #(.WAIT_CYCLES(50)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .nv_valid_i(nv_valid_i), .nv_value_i(nv_value_i),
        .setting_req_i(req), .driver_ready_check_enable_o(live),
        .check_pending_o(pend), .check_saved_o(saved),
        .save_done_o(sdone), .write_refused_o(refused),
        .motion_i(mot), .driver_ready_i(drdy),
        .pulse_start_o(pulse), .start_waiting_o(waiting),
        .conn_alarm_o(alarm), .alarm_code_o(code),
        .driver_ready_input_status_o(stat),
        .ready_local_o(rdy_l), .ready_remote_o(rdy_r));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    // Saved image is captured by the caller before reset clears the outputs
    task automatic do_reset(input logic v, input logic val);
        rst_n_i = 1'b0;
        nv_valid_i = v;
        nv_value_i = val;
        cyc(2);
        rst_n_i = 1'b1;
        cyc(2);
    endtask : do_reset

    task automatic start();
        mot.start = 1'b1;
        cyc(1);
        mot.start = 1'b0;
    endtask : start

    task automatic wait_alarm();
        int i;
        i = 0;
        while (i < 10 && alarm !== 1'b1)
        begin
            cyc(1);
            i++;
        end
    endtask : wait_alarm

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        n_errors = 0;
        n_compared = 0;
        cycles = 0;
        rst_n_i = 1'b0;
        nv_valid_i = 1'b0;
        nv_value_i = 1'b0;
        power = 1'b0;
        req = '0;
        mot = '0;
        do_reset(1'b0, 1'b0);
        check(8'(live), 8'h00);
        check(8'(rdy_l), 8'h01);
        check(8'(rdy_r), 8'h01);
        start();
        check(8'(pulse), 8'h01);
        cyc(2);
        req = '{wr: 1'b1, from_seq: 1'b1, wdata: 1'b1, save: 1'b0};
        cyc(1);
        check(8'(refused), 8'h01);
        check(8'(pend), 8'h00);
        // Strobe held up across the edge: the next access follows back to back
        req = '{wr: 1'b1, from_seq: 1'b0, wdata: 1'b1, save: 1'b0};
        cyc(1);
        req = '{wr: 1'b0, from_seq: 1'b0, wdata: 1'b0, save: 1'b1};
        check(8'(pend), 8'h01);
        cyc(1);
        check(8'(sdone), 8'h01);
        check(8'(saved), 8'h01);
        check(8'(live), 8'h00);
        // Write and save together: the older pending value is the one saved
        req = '{wr: 1'b1, from_seq: 1'b0, wdata: 1'b0, save: 1'b1};
        cyc(1);
        req = '0;
        check(8'(saved), 8'h01);
        check(8'(pend), 8'h00);
        do_reset(1'b1, saved);
        check(8'(live), 8'h01);
        check(8'(rdy_l), 8'h00);
        power = 1'b1;
        cyc(15);
        check(8'(stat), 8'h01);
        check(8'(rdy_r), 8'h01);
        start();
        check(8'(pulse), 8'h01);
        check(8'(waiting), 8'h00);
        mot.moving = 1'b1;
        cyc(3);
        check(8'(rdy_l), 8'h00);
        mot = '{start: 1'b0, moving: 1'b0, running: 1'b1, alarm_clr: 1'b0};
        cyc(2);
        check(8'(rdy_l), 8'h00);
        mot.running = 1'b0;
        power = 1'b0;
        cyc(3);
        start();
        check(8'(waiting), 8'h01);
        check(8'(pulse), 8'h00);
        // Driver settles on its tenth edge; the gate reacts one edge later
        power = 1'b1;
        cyc(10);
        check(8'(pulse), 8'h00);
        cyc(1);
        check(8'(pulse), 8'h01);
        power = 1'b0;
        cyc(3);
        start();
        // Alarm lands on the fiftieth edge after the start edge
        cyc(49);
        check(8'(alarm), 8'h00);
        cyc(1);
        check(8'(alarm), 8'h01);
        check(code, 8'h6F);
        check(8'(waiting), 8'h00);
        power = 1'b1;
        cyc(15);
        check(8'(rdy_l), 8'h00);
        start();
        check(8'(pulse), 8'h00);
        check(8'(alarm), 8'h01);
        mot.alarm_clr = 1'b1;
        cyc(1);
        mot.alarm_clr = 1'b0;
        cyc(1);
        check(8'(alarm), 8'h00);
        check(code, 8'h00);
        check(8'(rdy_l), 8'h01);
        power = 1'b0;
        cyc(3);
        start();
        cyc(30);
        start();
        cyc(45);
        check(8'(alarm), 8'h00);
        wait_alarm();
        check(8'(alarm), 8'h01);
        end_sim();
    end
endmodule : testbench
